/* File: crf_pkg.sv */
package crf_pkg;
    // Response kinds requested by the card logic
    typedef enum logic [2:0] {
        CRF_STATUS,
        CRF_STATUS_BUSY,
        CRF_REGISTER,
        CRF_OPCOND,
        CRF_ADDRESS,
        CRF_IFCOND
    } crf_kind_e;

    localparam int          CRF_SHORT_LEN   = 48;
    localparam int          CRF_LONG_LEN    = 136;
    localparam int          CRF_CRC_FIRST   = 7;
    localparam logic [5:0]  CRF_IDX_ONES    = 6'h3F;
    localparam logic [5:0]  CRF_IDX_ADDRESS = 6'h03;
    localparam logic [5:0]  CRF_IDX_IFCOND  = 6'h08;
    localparam logic [6:0]  CRF_CRC_ONES    = 7'h7F;
    localparam logic [6:0]  CRF_CRC_POLY    = 7'h09;
    localparam logic [19:0] CRF_IF_RSVD     = 20'h00000;
    localparam logic [3:0]  CRF_VOLT_STD    = 4'h1;
    localparam logic [7:0]  CRF_CNT_RESET   = 8'h00;
endpackage : crf_pkg

/* File: crf_response_framer.sv */
// Operation
// (R1) Response shifted out most significant bit first.
// (R2) Frame opens with start bit 0 then direction bit 0.
// (R3) CRC7 in bits 7:1 except operating-conditions response.
// (R4) Every frame ends with end bit 1.
// (R5) Status response is 48 bits, index in 45:40.
// (R6) Card status word sits in bits 39:8.
// (R7) Card may hold data line busy after each written block.
// (R8) Busy-variant response may assert busy from the response on.
// (R9) Register response 136 bits, bits 133:128 all ones.
// (R10) Register bits 127:1 sent; bit 0 replaced by end bit.
// (R11) Operating-conditions frame: ones in 45:40 and 7:1.
// (R12) Address response index 000011, upper argument holds relative address.
// (R13) Lower argument holds status bits 23,22,19,12:0.
// (R14) Interface-condition response index 001000, 39:20 zero.
// (R15) Voltage echoed in 19:16, check pattern in 15:8.
// (R16) Interface-condition response only when voltage accepted.
// (R17) Voltage code 0001b is the only accepted range.
// (R18) CRC7 polynomial x^7+x^3+1 from zero over bits 47..8.
module crf_response_framer (
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    input  wire logic               link_clk,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire crf_pkg::crf_kind_e req_kind,
    input  wire logic [5:0]         req_index,
    input  wire logic [31:0]        req_status,
    input  wire logic [127:0]       req_register,
    input  wire logic [31:0]        req_opcond,
    input  wire logic [15:0]        req_address,
    input  wire logic [11:0]        req_ifcond_arg,
    input  wire logic               busy_req,
    output logic                    resp_done,
    output logic                    cmd_out,
    output logic                    cmd_oe,
    output logic                    dat0_out,
    output logic                    dat0_oe
);
    import crf_pkg::*;

    // Frame image: short frames are left-justified in the 136-bit word
    logic [135:0] frame_d, frame_q;
    logic [7:0]   len_d, len_q;
    logic         pend_d, pend_q;
    logic         busyf_d, busyf_q;
    logic         tog_d, tog_q;
    logic         opcf_d, opcf_q;
    logic         ack_s1_q, ack_s2_q, ack_s3_q;
    logic         ack_ltog_q, ack_ltog_d;
    logic         accept;

    // Condensed status for the address response
    function automatic logic [15:0] crf_condense(input logic [31:0] st);
        crf_condense = {st[23], st[22], st[19], st[12:0]};
    endfunction : crf_condense

    // Clock-domain frame assembly
    always_comb begin
        frame_d = frame_q;
        len_d   = len_q;
        pend_d  = pend_q;
        busyf_d = busyf_q;
        tog_d   = tog_q;
        opcf_d  = opcf_q;
        accept  = 1'b0;
        // (R17) voltage acceptance check
        if (req_valid && req_ready) begin
            // (R16) refused voltage sends nothing
            if (req_kind == CRF_IFCOND && req_ifcond_arg[11:8] != CRF_VOLT_STD) begin
                accept = 1'b0;
            end else begin
                accept  = 1'b1;
                pend_d  = 1'b1;
                tog_d   = ~tog_q;
                busyf_d = (req_kind == CRF_STATUS_BUSY);
                opcf_d  = (req_kind == CRF_OPCOND);
                len_d   = 8'(CRF_SHORT_LEN);
                case (req_kind)
                    CRF_STATUS, CRF_STATUS_BUSY: begin
                        // (R5) (R6) index and status fields
                        frame_d = {2'b00, req_index, req_status, 8'h00, 88'h0};
                    end
                    CRF_REGISTER: begin
                        // (R9) (R10) long frame, bit 0 becomes end bit
                        frame_d = {2'b00, CRF_IDX_ONES, req_register[127:1], 1'b1};
                        len_d   = 8'(CRF_LONG_LEN);
                    end
                    CRF_OPCOND: begin
                        // (R11) fixed ones, no computed CRC
                        frame_d = {2'b00, CRF_IDX_ONES, req_opcond, CRF_CRC_ONES, 1'b1, 88'h0};
                    end
                    CRF_ADDRESS: begin
                        // (R12) (R13) address plus condensed status
                        frame_d = {2'b00, CRF_IDX_ADDRESS, req_address, crf_condense(req_status),
                                   8'h00, 88'h0};
                    end
                    CRF_IFCOND: begin
                        // (R14) (R15) echo of voltage and pattern
                        frame_d = {2'b00, CRF_IDX_IFCOND, CRF_IF_RSVD, req_ifcond_arg,
                                   8'h00, 88'h0};
                    end
                    default: begin
                        frame_d = frame_q;
                    end
                endcase
            end
        end else if (pend_q && (ack_s2_q == ack_s3_q) && (ack_s3_q == tog_q)) begin
            pend_d = 1'b0;
        end
    end

    assign req_ready = ~pend_q;
    assign resp_done = pend_q && (ack_s2_q == ack_s3_q) && (ack_s3_q == tog_q);

    // Clock-domain registers and acknowledge synchroniser
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_q  <= '0;
            len_q    <= CRF_CNT_RESET;
            pend_q   <= 1'b0;
            busyf_q  <= 1'b0;
            tog_q    <= 1'b0;
            opcf_q   <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            frame_q  <= frame_d;
            len_q    <= len_d;
            pend_q   <= pend_d;
            busyf_q  <= busyf_d;
            tog_q    <= tog_d;
            opcf_q   <= opcf_d;
            ack_s1_q <= ack_ltog_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // Link side: request toggle and busy level cross in by three flops
    logic       rq_s1_q, rq_s2_q, rq_s3_q;
    logic       bz_s1_q, bz_s2_q, bz_s3_q;
    logic       act_q, act_d;
    logic       isopc_q, isopc_d;
    logic       lbusy_q, lbusy_d;
    logic [7:0] cnt_q, cnt_d;
    logic [6:0] crc_q, crc_d;
    logic       out_q, out_d;
    logic       oe_q, oe_d;
    logic       go;
    logic       bit_now;

    assign go      = (rq_s2_q == rq_s3_q) && (rq_s3_q != ack_ltog_q) && !act_q;
    assign bit_now = frame_q[8'(135) - cnt_q];

    // Serialiser next state; frame_q is stable while the toggle is pending
    always_comb begin
        act_d      = act_q;
        cnt_d      = cnt_q;
        crc_d      = crc_q;
        out_d      = 1'b1;
        oe_d       = 1'b0;
        ack_ltog_d = ack_ltog_q;
        isopc_d    = isopc_q;
        lbusy_d    = lbusy_q;
        if (go) begin
            act_d   = 1'b1;
            cnt_d   = CRF_CNT_RESET;
            // (R18) remainder starts at zero
            crc_d   = 7'h00;
            // Kind flag, not the image: a status reply to index 63 also has ones there
            isopc_d = opcf_q;
            lbusy_d = busyf_q;
        end else if (act_q) begin
            oe_d = 1'b1;
            // (R1) msb first walk through the image
            out_d = bit_now;
            if (len_q == 8'(CRF_SHORT_LEN) && cnt_q >= 8'(CRF_SHORT_LEN - 1 - CRF_CRC_FIRST)
                && cnt_q < 8'(CRF_SHORT_LEN - 1) && !isopc_q) begin
                // (R3) computed CRC in bits 7:1
                out_d = crc_q[6];
                crc_d = {crc_q[5:0], 1'b0};
            end else if (cnt_q == len_q - 8'd1) begin
                // (R4) end bit
                out_d = 1'b1;
            end else begin
                // (R18) divide by x^7+x^3+1
                crc_d = {crc_q[5:0], 1'b0} ^ ((crc_q[6] ^ bit_now) ? CRF_CRC_POLY : 7'h00);
            end
            // (R2) start and direction bits come from the zero image head
            cnt_d = cnt_q + 8'd1;
            if (cnt_q == len_q - 8'd1) begin
                act_d      = 1'b0;
                ack_ltog_d = rq_s3_q;
            end
        end
        // (R7) (R8) busy held from response start while the core asks
        if (!(bz_s2_q == bz_s3_q && bz_s3_q) && !act_q) begin
            lbusy_d = 1'b0;
        end
    end

    // Link-clock registers
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            rq_s1_q    <= 1'b0;
            rq_s2_q    <= 1'b0;
            rq_s3_q    <= 1'b0;
            bz_s1_q    <= 1'b0;
            bz_s2_q    <= 1'b0;
            bz_s3_q    <= 1'b0;
            ack_ltog_q <= 1'b0;
            act_q      <= 1'b0;
            isopc_q    <= 1'b0;
            lbusy_q    <= 1'b0;
            cnt_q      <= CRF_CNT_RESET;
            crc_q      <= 7'h00;
            out_q      <= 1'b1;
            oe_q       <= 1'b0;
        end else begin
            rq_s1_q    <= tog_q;
            rq_s2_q    <= rq_s1_q;
            rq_s3_q    <= rq_s2_q;
            bz_s1_q    <= busy_req;
            bz_s2_q    <= bz_s1_q;
            bz_s3_q    <= bz_s2_q;
            ack_ltog_q <= ack_ltog_d;
            act_q      <= act_d;
            isopc_q    <= isopc_d;
            lbusy_q    <= lbusy_d;
            cnt_q      <= cnt_d;
            crc_q      <= crc_d;
            out_q      <= out_d;
            oe_q       <= oe_d;
        end
    end

    // Data line busy: drive low when busy is wanted, block-end or busy-response
    logic dat_busy;
    assign dat_busy = (bz_s2_q == bz_s3_q) && bz_s3_q && (lbusy_q || !act_q);
    assign cmd_out  = out_q;
    assign cmd_oe   = oe_q;
    assign dat0_out = 1'b0;
    assign dat0_oe  = dat_busy;

    // (R2) two zero head bits
    sequence s_head_zero;
        !out_q ##1 !out_q;
    endsequence
    // (R2) start bit low on the first driven cycle
    a_start_bit_low: assert property (@(posedge link_clk) disable iff (!reset_n) // (R2)
        $rose(oe_q) |-> s_head_zero) else $error("start or direction bit not zero");
    // (R4) end bit high as the drive releases
    a_end_bit_high: assert property (@(posedge link_clk) disable iff (!reset_n) // (R4)
        $fell(oe_q) |-> $past(out_q)) else $error("end bit not one");
    // (R16) refused voltage produces no pending frame
    a_refuse_voltage: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R16)
        (req_valid && req_ready && req_kind == CRF_IFCOND && req_ifcond_arg[11:8] != CRF_VOLT_STD)
        |=> !pend_q) else $error("unaccepted voltage queued");
    // (R5) short frame length
    a_short_length: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R5)
        (accept && req_kind != CRF_REGISTER) |=> len_q == 8'(CRF_SHORT_LEN)) else $error("bad length");
    // (R9) long frame reserved field
    a_long_field: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R9)
        (accept && req_kind == CRF_REGISTER) |=> frame_q[133:128] == CRF_IDX_ONES && len_q == 8'(CRF_LONG_LEN))
        else $error("register frame malformed");
    // (R12) address index
    a_address_index: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R12)
        (accept && req_kind == CRF_ADDRESS) |=> frame_q[133:128] == CRF_IDX_ADDRESS) else $error("bad index");
    // (R14) interface-condition reserved zero
    a_ifcond_rsvd: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R14)
        (accept && req_kind == CRF_IFCOND) |=> frame_q[127:108] == CRF_IF_RSVD) else $error("reserved nonzero");
    // (R1) third output bit equals image bit 133
    a_msb_first: assert property (@(posedge link_clk) disable iff (!reset_n) // (R1)
        (act_q && cnt_q == 8'd2) |=> out_q == frame_q[133]) else $error("bit order wrong");
    // (R5) status index field
    a_status_index: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R5)
        (accept && (req_kind == CRF_STATUS || req_kind == CRF_STATUS_BUSY))
        |=> frame_q[133:128] == $past(req_index)) else $error("status index wrong");
    // (R6) status word placement
    a_status_word: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R6)
        (accept && (req_kind == CRF_STATUS || req_kind == CRF_STATUS_BUSY))
        |=> frame_q[127:96] == $past(req_status)) else $error("status word misplaced");
    // (R10) register tail bits
    a_register_tail: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R10)
        (accept && req_kind == CRF_REGISTER)
        |=> frame_q[127:1] == $past(req_register[127:1]) && frame_q[0]) else $error("register tail wrong");
    // (R11) fixed ones in check field
    a_opcond_ones: assert property (@(posedge link_clk) disable iff (!reset_n) // (R11)
        (act_q && isopc_q && cnt_q >= 8'(CRF_SHORT_LEN - 1 - CRF_CRC_FIRST) && cnt_q < 8'(CRF_SHORT_LEN - 1))
        |=> out_q) else $error("opcond check field not ones");
    // (R13) condensed status bits
    a_address_status: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R13)
        (accept && req_kind == CRF_ADDRESS)
        |=> frame_q[111:96] == {$past(req_status[23]), $past(req_status[22]), $past(req_status[19]),
                                $past(req_status[12:0])}) else $error("condensed status wrong");
    // (R15) voltage and pattern echo
    a_ifcond_echo: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R15)
        (accept && req_kind == CRF_IFCOND) |=> frame_q[107:96] == $past(req_ifcond_arg))
        else $error("echo wrong");
    // (R8) plain frame keeps data free
    a_busy_plain: assert property (@(posedge link_clk) disable iff (!reset_n) // (R8)
        (act_q && !lbusy_q) |-> !dat0_oe) else $error("busy during plain frame");
endmodule : crf_response_framer

/* File: crf_host_model.sv */
// Host end of the command line: collects each response bit by bit
module crf_host_model (
    input  wire logic    link_clk,
    input  wire logic    clr,
    input  wire logic    cmd_out,
    input  wire logic    cmd_oe,
    output logic [135:0] frame,
    output int unsigned  nbits
);
    timeunit 1ns;
    timeprecision 1ps;
    // first bit ends highest
    // Sampled on the falling edge, away from the card's launch edge
    always @(negedge link_clk or posedge clr) begin
        if (clr) begin
            frame <= '0;
            nbits <= 0;
        end else if (cmd_oe === 1'h1) begin
            frame <= {frame[134:0], cmd_out};
            nbits <= nbits + 1;
        end
    end
endmodule : crf_host_model

/* File: tb_card_response_framer.sv */
module tb_card_response_framer;
    timeunit 1ns;
    timeprecision 1ps;
    import crf_pkg::*;
    logic ref_clk = 0, link_clk = 0, reset_n = 0, req_valid = 0, busy_req = 0, clr = 0;
    crf_kind_e req_kind = CRF_STATUS;
    logic [5:0] req_index = 6'h0;
    logic [31:0] req_status = 32'h0;
    logic [127:0] req_register = {4{32'hC3A596E1}};
    logic [15:0] req_address = 16'h7A5C;
    logic [11:0] req_ifcond_arg = 12'h0;
    logic req_ready, resp_done, cmd_out, cmd_oe, dat0_out, dat0_oe;
    logic [135:0] frame;
    int unsigned nbits;
    int num_errors = 0, checks_done = 0, cyc = 0;
    // Clocks; link clock free-running so the card can always answer
    initial forever #2.5 ref_clk = ~ref_clk;
    initial begin
        #13;
        forever #40 link_clk = ~link_clk;
    end
    crf_response_framer u_crf_response_framer (.ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk),
        .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_index(req_index),
        .req_status(req_status), .req_register(req_register), .req_opcond(req_status),
        .req_address(req_address), .req_ifcond_arg(req_ifcond_arg), .busy_req(busy_req),
        .resp_done(resp_done), .cmd_out(cmd_out), .cmd_oe(cmd_oe), .dat0_out(dat0_out), .dat0_oe(dat0_oe));
    crf_host_model u_crf_host_model (.link_clk(link_clk), .clr(clr), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
        .frame(frame), .nbits(nbits));
    task automatic cmp(string n, logic [135:0] e, logic [135:0] s);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    // Expected short frame; CRC worked out bit-serially from zero
    function automatic logic [135:0] e48(logic [5:0] ix, logic [31:0] b, logic opc);
        logic [47:0] f;
        logic [6:0] c;
        f = {2'h0, ix, b, 8'h01};
        c = 7'h0;
        for (int i = 47; i >= 8; i--) c = {c[5:0], 1'h0} ^ ((f[i] ^ c[6]) ? 7'h09 : 7'h00);
        f[7:1] = opc ? 7'h7F : c;
        return {88'h0, f};
    endfunction : e48
    task automatic go(crf_kind_e k, logic [5:0] ix, logic [31:0] d, logic [11:0] a);
        for (int i = 0; i < 100 && req_ready !== 1'h1; i++) @(negedge ref_clk);
        clr = 1;
        req_kind = k;
        req_index = ix;
        req_status = d;
        req_ifcond_arg = a;
        req_valid = 1;
        @(negedge ref_clk);
        clr = 0;
        req_valid = 0;
    endtask : go
    task automatic fin(string n, logic [135:0] e, int unsigned len);
        for (int i = 0; i < 4000 && resp_done !== 1'h1; i++) @(negedge ref_clk);
        cmp({n, " done"}, 1, resp_done);
        // Done rises as the end bit goes out, so wait for the line release
        for (int i = 0; i < 40 && cmd_oe !== 1'h0; i++) @(negedge ref_clk);
        cmp({n, " released"}, 0, cmd_oe);
        cmp({n, " length"}, len, nbits);
        cmp(n, e, frame);
        $display("test %s over", n);
    endtask : fin
    task automatic t_status;
        go(CRF_STATUS, 6'h2A, 32'h800100F3, 12'h0);
        fin("status", e48(6'h2A, 32'h800100F3, 0), 48);
        go(CRF_STATUS, 6'h3F, 32'h0000FFFF, 12'h0);
        fin("status index 63", e48(6'h3F, 32'h0000FFFF, 0), 48);
    endtask : t_status
    task automatic t_register;
        go(CRF_REGISTER, 6'h0, 32'h0, 12'h0);
        fin("register", {2'h0, 6'h3F, req_register[127:1], 1'h1}, 136);
    endtask : t_register
    task automatic t_opcond;
        go(CRF_OPCOND, 6'h0, 32'h80FF8000, 12'h0);
        fin("opcond", e48(6'h3F, 32'h80FF8000, 1), 48);
    endtask : t_opcond
    task automatic t_address;
        logic [31:0] s;
        s = 32'h00C81A5F;
        go(CRF_ADDRESS, 6'h0, s, 12'h0);
        fin("address", e48(6'h03, {16'h7A5C, s[23], s[22], s[19], s[12:0]}, 0), 48);
    endtask : t_address
    task automatic t_ifcond;
        logic [3:0] v[5] = '{4'h1, 4'h0, 4'h2, 4'h4, 4'h8};
        foreach (v[j]) begin
            go(CRF_IFCOND, 6'h0, 32'h0, {v[j], 8'hAA});
            if (v[j] == 4'h1) fin("ifcond", e48(6'h08, {20'h0, 4'h1, 8'hAA}, 0), 48);
            else begin
                repeat (400) @(negedge ref_clk);
                cmp("refused frame", 0, nbits);
                cmp("refused ready", 1, req_ready);
            end
        end
    endtask : t_ifcond
    task automatic t_busy;
        busy_req = 1;
        repeat (100) @(negedge ref_clk);
        cmp("idle busy", 1, dat0_oe);
        cmp("busy level", 0, dat0_out);
        go(CRF_STATUS, 6'h18, 32'h00000900, 12'h0);
        repeat (600) @(negedge ref_clk);
        cmp("plain frame busy", 0, dat0_oe);
        fin("status under busy", e48(6'h18, 32'h00000900, 0), 48);
        go(CRF_STATUS_BUSY, 6'h0C, 32'h00000B00, 12'h0);
        repeat (600) @(negedge ref_clk);
        cmp("busy variant", 1, dat0_oe);
        fin("status busy", e48(6'h0C, 32'h00000B00, 0), 48);
        busy_req = 0;
        repeat (100) @(negedge ref_clk);
        cmp("busy off", 0, dat0_oe);
    endtask : t_busy
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Ceiling well above the roughly 10000 cycles the tests take
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        reset_n = 1;
        cmp("idle line", 0, cmd_oe);
        t_status();
        t_register();
        t_opcond();
        t_address();
        t_ifcond();
        t_busy();
        wrap_up();
    end
endmodule : tb_card_response_framer
